// *** vet_pkg.sv ***
// Purpose: shared constants and types for the video encoder timing and format block
// Assumes: byte-wide register port, one pixel clock, synchronous active-high reset
// Notes: register offsets sit at their printed addresses; unmapped reads return zero

package vet_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_FMT = 8'h01;
    localparam logic [7:0] ADDR_BKG = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0f;
    localparam logic [7:0] ADDR_SC0 = 8'h11;
    localparam logic [7:0] ADDR_SC1 = 8'h12;
    localparam logic [7:0] ADDR_SC2 = 8'h13;
    localparam logic [7:0] ADDR_SC3 = 8'h14;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_MODE = 8'h01;
    localparam logic [7:0] RST_FMT = 8'h12;
    // rgb 3:3:2 pure blue
    localparam logic [7:0] RST_BKG = 8'h03;
    localparam logic [31:0] RST_SC_WORD = 32'h43e0f83e;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================================
    // field positions
    localparam int MODE_STD_LSB = 5;
    localparam int MODE_PROG_BIT = 3;
    localparam int MODE_IN_BIT = 2;
    localparam int FMT_SETUP_BIT = 1;
    localparam int FMT_BARS_BIT = 7;

    // ==========================================================
    // analog standards
    typedef enum logic [2:0] {
        VET_STD_NTSC_601 = 3'b000,
        VET_STD_NTSC_RS170A = 3'b001,
        VET_STD_PAL_BDGHI = 3'b010,
        VET_STD_PAL_M = 3'b011,
        VET_STD_PAL_NC = 3'b100,
        VET_STD_PAL_N = 3'b101
    } vet_std_t;

    // ==========================================================
    // vertical timing, line numbers count from one
    localparam logic [9:0] FIRST_LINE = 10'd1;
    localparam logic [9:0] NTSC_FRAME_LINES = 10'd525;
    localparam logic [9:0] NTSC_FIELD2_FIRST = 10'd264;
    localparam logic [9:0] NTSC_PROG_SHORT = 10'd262;
    localparam logic [9:0] NTSC_PROG_LONG = 10'd263;
    localparam logic [9:0] NTSC_ODD_FIRST = 10'd22;
    localparam logic [9:0] NTSC_ODD_LAST = 10'd261;
    localparam logic [9:0] NTSC_EVEN_FIRST = 10'd285;
    localparam logic [9:0] NTSC_EVEN_LAST = 10'd524;
    localparam logic [9:0] PAL_FRAME_LINES = 10'd625;
    localparam logic [9:0] PAL_FIELD2_FIRST = 10'd313;
    localparam logic [9:0] PAL_PROG_SHORT = 10'd312;
    localparam logic [9:0] PAL_PROG_LONG = 10'd313;
    localparam logic [9:0] PAL_ODD_FIRST = 10'd23;
    localparam logic [9:0] PAL_ODD_LAST = 10'd310;
    localparam logic [9:0] PAL_EVEN_FIRST = 10'd336;
    localparam logic [9:0] PAL_EVEN_LAST = 10'd623;
    localparam logic [2:0] NTSC_SEQ_LAST = 3'd3;
    localparam logic [2:0] PAL_SEQ_LAST = 3'd7;
    localparam logic [2:0] SEQ_FIRST = 3'd0;

    // ==========================================================
    // video levels and test bars
    localparam logic [7:0] BLANK_Y = 8'h10;
    localparam logic [7:0] BLANK_C = 8'h80;
    localparam int BAR_COUNT = 8;
    // white, yellow, cyan, green, magenta, red, blue, black from index 0
    localparam logic [BAR_COUNT-1:0][23:0] BAR_RGB = {24'h000000, 24'h0000ff, 24'hff0000, 24'hff00ff,
                                                      24'h00ff00, 24'h00ffff, 24'hffff00, 24'hffffff};

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } vet_pixel_t;

    typedef struct packed {
        logic [7:0] mode_ctl;
        logic [7:0] fmt_ctl;
        logic [7:0] bkg;
        logic [31:0] sc_word;
        logic [7:0] rdata;
        logic rvalid;
        logic [10:0] pix_cnt;
        logic [9:0] line;
        logic field_even;
        logic prog_long;
        logic [2:0] field_seq;
        logic field_start;
        logic sc_reset;
        logic [10:0] bar_cnt;
        logic [2:0] bar_idx;
        logic active;
        vet_pixel_t pix;
    } vet_state_t;

    typedef struct packed {
        logic [31:0] phase;
    } vet_sc_state_t;

    // full-range rgb to studio-range ycbcr, fixed point with rounding
    function automatic vet_pixel_t vet_rgb_to_ycc(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
        int ri;
        int gi;
        int bi;
        vet_pixel_t p;
        ri = int'(r);
        gi = int'(g);
        bi = int'(b);
        p.y = 8'(16 + ((66 * ri + 129 * gi + 25 * bi + 128) >>> 8));
        p.cb = 8'(128 + ((-38 * ri - 74 * gi + 112 * bi + 128) >>> 8));
        p.cr = 8'(128 + ((112 * ri - 94 * gi - 18 * bi + 128) >>> 8));
        return p;
    endfunction : vet_rgb_to_ycc

    // background byte is rgb 3:3:2, widened by bit replication
    function automatic vet_pixel_t vet_bkg_to_ycc(input logic [7:0] c);
        return vet_rgb_to_ycc({c[7:5], c[7:5], c[7:6]}, {c[4:2], c[4:2], c[4:3]}, {c[1:0], c[1:0], c[1:0], c[1:0]});
    endfunction : vet_bkg_to_ycc

endpackage : vet_pkg

// *** vet_subcarrier.sv ***
// Purpose: subcarrier phase accumulator driven by the pixel clock
// Assumes: increment word is stable between host writes
// Notes: a reset pulse clears the phase in place of one addition

`timescale 1ns/10ps

module vet_subcarrier (
    input wire logic clock,
    input wire logic srst,
    input wire logic [31:0] increment,
    input wire logic phase_reset,
    output logic [31:0] phase
);

    // ==========================================================
    // state
    vet_pkg::vet_sc_state_t st;
    vet_pkg::vet_sc_state_t next_st;

    always_comb begin
        next_st = st;
        if (phase_reset) begin
            next_st.phase = '0;
        end else begin
            next_st.phase = st.phase + increment;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign phase = st.phase;

    // ==========================================================
    // checks
    property p_phase_clear;
        @(posedge clock) disable iff (srst) phase_reset |=> (phase == '0);
    endproperty
    a_phase_clear: assert property (p_phase_clear) else $error("phase not cleared after reset pulse");

    property p_phase_step;
        @(posedge clock) disable iff (srst) !phase_reset |=> (phase == $past(st.phase) + $past(increment));
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase did not advance by increment");

endmodule : vet_subcarrier

// *** vet_timing_format.sv ***
// Purpose: raster timing, output source selection and subcarrier control for the analog encoder
// Assumes: host registers reached over a byte port at the encoder bank offsets
// Notes: field boundaries fall on whole-line edges; half lines are always blanked
// Notes on behaviour
// - four timing modes: 625 interlaced, 525 interlaced, and progressive variants of both.
// - timing mode comes from a field of the mode control register at 0x00.
// - half lines carry no input; 240 NTSC or 288 PAL active lines per field.
// - NTSC interlaced active lines 22-261 odd field, 285-524 even field.
// - PAL interlaced active lines 23-310 odd field, 336-623 even field.
// - NTSC-type interlaced gives two 262.5-line fields per 525-line frame; here field one is lines 1-263 and field two lines 264-525.
// - PAL interlaced gives two 312.5-line fields per 625-line frame; here field one is lines 1-312 and field two lines 313-625.
// - progressive repeats odd field with alternating lengths keeping average frame rate.
// - input mode 0, and reset, outputs one solid colour of 256.
// - solid colour from 0x08 as rgb 3:3:2, no gamma, resets to blue.
// - input mode 1 outputs the camera image from the front end.
// - after reset the standard is NTSC-M with 601 timing.
// - setup bit in 0x01 cleared removes the 7.5 IRE pedestal.
// - subcarrier from pixel clock by 32-bit word of four bytes, reset 43e0f83e.
// - subcarrier phase cleared every four NTSC fields, eight PAL fields; PAL-M here follows the 525-line count and clears every four.
// - test bars enable replaces incoming pixel data with generated bars.
// - bars only in master timing mode; timing stays unchanged.
// - bars join the path after chroma interpolation, before luma delay.
// - 100% amplitude and saturation bars, same values for PAL.

`timescale 1ns/10ps

module vet_timing_format #(
    parameter int LINE_SAMPLES_525 = 858,
    parameter int LINE_SAMPLES_625 = 864,
    parameter int ACTIVE_START = 122,
    parameter int ACTIVE_SAMPLES = 720
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic master_mode,
    input wire vet_pkg::vet_pixel_t pix_in,
    output vet_pkg::vet_pixel_t pix_out,
    output logic active_video,
    output logic [9:0] line_number,
    output logic field_id,
    output logic [2:0] field_sequence,
    output logic field_start,
    output logic [2:0] analog_standard,
    output logic progressive,
    output logic setup_level_enable,
    output logic [31:0] subcarrier_phase
);

    localparam int BAR_SAMPLES = ACTIVE_SAMPLES / vet_pkg::BAR_COUNT;

    // ==========================================================
    // state and decode
    vet_pkg::vet_state_t st;
    vet_pkg::vet_state_t next_st;
    logic is625;
    logic prog;
    logic eol;
    logic [9:0] last_line;
    logic [9:0] field2_first;
    logic [2:0] seq_last;
    logic line_active;
    logic pix_window;
    logic bars_sel;
    logic new_field;
    vet_pkg::vet_std_t std_sel;

    assign std_sel = vet_pkg::vet_std_t'(st.mode_ctl[vet_pkg::MODE_STD_LSB +: 3]);
    assign is625 = (std_sel == vet_pkg::VET_STD_PAL_BDGHI) || (std_sel == vet_pkg::VET_STD_PAL_NC)
                   || (std_sel == vet_pkg::VET_STD_PAL_N);
    assign prog = st.mode_ctl[vet_pkg::MODE_PROG_BIT];
    assign eol = st.pix_cnt == (is625 ? 11'(LINE_SAMPLES_625 - 1) : 11'(LINE_SAMPLES_525 - 1));
    assign field2_first = is625 ? vet_pkg::PAL_FIELD2_FIRST : vet_pkg::NTSC_FIELD2_FIRST;
    assign seq_last = is625 ? vet_pkg::PAL_SEQ_LAST : vet_pkg::NTSC_SEQ_LAST;

    // progressive alternates short and long fields
    always_comb begin
        if (prog) begin
            if (is625) begin
                last_line = st.prog_long ? vet_pkg::PAL_PROG_LONG : vet_pkg::PAL_PROG_SHORT;
            end else begin
                last_line = st.prog_long ? vet_pkg::NTSC_PROG_LONG : vet_pkg::NTSC_PROG_SHORT;
            end
        end else begin
            last_line = is625 ? vet_pkg::PAL_FRAME_LINES : vet_pkg::NTSC_FRAME_LINES;
        end
    end

    always_comb begin
        if (is625) begin
            line_active = ((st.line >= vet_pkg::PAL_ODD_FIRST) && (st.line <= vet_pkg::PAL_ODD_LAST))
                          || (!prog && (st.line >= vet_pkg::PAL_EVEN_FIRST) && (st.line <= vet_pkg::PAL_EVEN_LAST));
        end else begin
            line_active = ((st.line >= vet_pkg::NTSC_ODD_FIRST) && (st.line <= vet_pkg::NTSC_ODD_LAST))
                          || (!prog && (st.line >= vet_pkg::NTSC_EVEN_FIRST) && (st.line <= vet_pkg::NTSC_EVEN_LAST));
        end
    end

    assign pix_window = (st.pix_cnt >= 11'(ACTIVE_START)) && (st.pix_cnt <= 11'(ACTIVE_START + ACTIVE_SAMPLES - 1));
    assign bars_sel = st.fmt_ctl[vet_pkg::FMT_BARS_BIT] && master_mode;

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        new_field = 1'b0;
        next_st.rvalid = 1'b0;
        next_st.field_start = 1'b0;
        next_st.sc_reset = 1'b0;

        // register writes; unmapped offsets are ignored
        if (reg_wr) begin
            case (reg_addr)
                vet_pkg::ADDR_MODE: next_st.mode_ctl = reg_wdata;
                vet_pkg::ADDR_FMT: next_st.fmt_ctl = reg_wdata;
                vet_pkg::ADDR_BKG: next_st.bkg = reg_wdata;
                vet_pkg::ADDR_SC0: next_st.sc_word[7:0] = reg_wdata;
                vet_pkg::ADDR_SC1: next_st.sc_word[15:8] = reg_wdata;
                vet_pkg::ADDR_SC2: next_st.sc_word[23:16] = reg_wdata;
                vet_pkg::ADDR_SC3: next_st.sc_word[31:24] = reg_wdata;
                default: ;
            endcase
        end

        // register reads; unmapped offsets answer zero
        if (reg_rd) begin
            next_st.rvalid = 1'b1;
            case (reg_addr)
                vet_pkg::ADDR_MODE: next_st.rdata = st.mode_ctl;
                vet_pkg::ADDR_FMT: next_st.rdata = st.fmt_ctl;
                vet_pkg::ADDR_BKG: next_st.rdata = st.bkg;
                vet_pkg::ADDR_STATUS: next_st.rdata = {st.field_seq, st.field_even, st.prog_long, st.active, 2'b00};
                vet_pkg::ADDR_SC0: next_st.rdata = st.sc_word[7:0];
                vet_pkg::ADDR_SC1: next_st.rdata = st.sc_word[15:8];
                vet_pkg::ADDR_SC2: next_st.rdata = st.sc_word[23:16];
                vet_pkg::ADDR_SC3: next_st.rdata = st.sc_word[31:24];
                default: next_st.rdata = vet_pkg::READ_ZERO;
            endcase
        end

        // bar position within the active window
        if (pix_window) begin
            if (st.bar_cnt == 11'(BAR_SAMPLES - 1)) begin
                next_st.bar_cnt = '0;
                next_st.bar_idx = st.bar_idx + 3'd1;
            end else begin
                next_st.bar_cnt = st.bar_cnt + 11'd1;
            end
        end

        // line counter wraps at frame length
        if (eol) begin
            next_st.pix_cnt = '0;
            next_st.bar_cnt = '0;
            next_st.bar_idx = '0;
            // >= so a standard switch past the new frame end still wraps at once
            if (st.line >= last_line) begin
                next_st.line = vet_pkg::FIRST_LINE;
                next_st.field_even = 1'b0;
                new_field = 1'b1;
                if (prog) begin
                    next_st.prog_long = !st.prog_long;
                end
            end else begin
                next_st.line = st.line + 10'd1;
                if (!prog && (next_st.line == field2_first)) begin
                    next_st.field_even = 1'b1;
                    new_field = 1'b1;
                end
            end
        end else begin
            next_st.pix_cnt = st.pix_cnt + 11'd1;
        end

        if (new_field) begin
            next_st.field_start = 1'b1;
            if (st.field_seq >= seq_last) begin
                next_st.field_seq = vet_pkg::SEQ_FIRST;
                next_st.sc_reset = 1'b1;
            end else begin
                next_st.field_seq = st.field_seq + 3'd1;
            end
        end

        // output source select; timing above never depends on it
        next_st.active = line_active && pix_window;
        if (!next_st.active) begin
            next_st.pix = '{y: vet_pkg::BLANK_Y, cb: vet_pkg::BLANK_C, cr: vet_pkg::BLANK_C};
        end else if (bars_sel) begin
            next_st.pix = vet_pkg::vet_rgb_to_ycc(vet_pkg::BAR_RGB[st.bar_idx][23:16],
                                                  vet_pkg::BAR_RGB[st.bar_idx][15:8],
                                                  vet_pkg::BAR_RGB[st.bar_idx][7:0]);
        end else if (st.mode_ctl[vet_pkg::MODE_IN_BIT]) begin
            next_st.pix = pix_in;
        end else begin
            next_st.pix = vet_pkg::vet_bkg_to_ycc(st.bkg);
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clock) begin
        if (srst) begin
            st <= '0;
            st.mode_ctl <= vet_pkg::RST_MODE;
            st.fmt_ctl <= vet_pkg::RST_FMT;
            st.bkg <= vet_pkg::RST_BKG;
            st.sc_word <= vet_pkg::RST_SC_WORD;
            st.line <= vet_pkg::FIRST_LINE;
            st.pix <= '{y: vet_pkg::BLANK_Y, cb: vet_pkg::BLANK_C, cr: vet_pkg::BLANK_C};
        end else begin
            st <= next_st;
        end
    end

    // the accumulator takes whatever word the host loaded, so pal words are software's duty
    vet_subcarrier u_subcarrier (
        .clock(clock),
        .srst(srst),
        .increment(st.sc_word),
        .phase_reset(st.sc_reset),
        .phase(subcarrier_phase)
    );

    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign pix_out = st.pix;
    assign active_video = st.active;
    assign line_number = st.line;
    assign field_id = st.field_even;
    assign field_sequence = st.field_seq;
    assign field_start = st.field_start;
    assign analog_standard = st.mode_ctl[vet_pkg::MODE_STD_LSB +: 3];
    assign progressive = st.mode_ctl[vet_pkg::MODE_PROG_BIT];
    assign setup_level_enable = st.fmt_ctl[vet_pkg::FMT_SETUP_BIT];

    // ==========================================================
    // checks
    sequence s_ntsc_frame_end;
        !is625 && !prog && (st.line == vet_pkg::NTSC_FRAME_LINES) && eol;
    endsequence
    sequence s_frame_restart;
        (st.line == vet_pkg::FIRST_LINE) && !st.field_even && st.field_start;
    endsequence

    property p_ntsc_wrap;
        @(posedge clock) disable iff (srst) s_ntsc_frame_end |=> s_frame_restart;
    endproperty
    a_ntsc_wrap: assert property (p_ntsc_wrap) else $error("ntsc frame did not wrap after line 525");

    property p_pal_wrap;
        @(posedge clock) disable iff (srst)
            (is625 && !prog && (st.line == vet_pkg::PAL_FRAME_LINES) && eol) |=> s_frame_restart;
    endproperty
    a_pal_wrap: assert property (p_pal_wrap) else $error("pal frame did not wrap after line 625");

    property p_even_field;
        @(posedge clock) disable iff (srst)
            (!prog && (st.line == field2_first - 10'd1) && eol) |=> (st.field_even && st.field_start);
    endproperty
    a_even_field: assert property (p_even_field) else $error("second field did not start");

    property p_ntsc_active;
        @(posedge clock) disable iff (srst)
            (!is625 && !prog && pix_window && (st.line >= vet_pkg::NTSC_EVEN_FIRST)
             && (st.line <= vet_pkg::NTSC_EVEN_LAST)) |=> active_video;
    endproperty
    a_ntsc_active: assert property (p_ntsc_active) else $error("ntsc even field line not active");

    property p_pal_blank;
        @(posedge clock) disable iff (srst)
            (is625 && ((st.line < vet_pkg::PAL_ODD_FIRST) || (st.line == vet_pkg::PAL_ODD_LAST + 10'd1)))
            |=> !active_video ##1 (pix_out.y == vet_pkg::BLANK_Y) || active_video;
    endproperty
    a_pal_blank: assert property (p_pal_blank) else $error("pal blanking line shown as active");

    property p_prog_alternate;
        @(posedge clock) disable iff (srst)
            (prog && (st.line == last_line) && eol) |=> (st.prog_long != $past(st.prog_long)) && !st.field_even;
    endproperty
    a_prog_alternate: assert property (p_prog_alternate) else $error("progressive field length did not alternate");

    property p_solid_colour;
        @(posedge clock) disable iff (srst)
            (line_active && pix_window && !bars_sel && !st.mode_ctl[vet_pkg::MODE_IN_BIT])
            |=> (pix_out == vet_pkg::vet_bkg_to_ycc($past(st.bkg)));
    endproperty
    a_solid_colour: assert property (p_solid_colour) else $error("solid colour not output in mode 0");

    property p_camera;
        @(posedge clock) disable iff (srst)
            (line_active && pix_window && !bars_sel && st.mode_ctl[vet_pkg::MODE_IN_BIT]) |=> (pix_out == $past(pix_in));
    endproperty
    a_camera: assert property (p_camera) else $error("camera pixel not passed in mode 1");

    property p_bars;
        @(posedge clock) disable iff (srst)
            (line_active && pix_window && bars_sel && (st.bar_idx == 3'd0)) |=> (pix_out.y == 8'heb);
    endproperty
    a_bars: assert property (p_bars) else $error("first bar is not full white");

    property p_seq_reset;
        @(posedge clock) disable iff (srst)
            st.sc_reset |-> (st.field_start && (st.field_seq == vet_pkg::SEQ_FIRST));
    endproperty
    a_seq_reset: assert property (p_seq_reset) else $error("subcarrier cleared off sequence start");

    property p_reset_defaults;
        @(posedge clock) srst |=> (st.mode_ctl == vet_pkg::RST_MODE) && (st.sc_word == vet_pkg::RST_SC_WORD)
                                  && (st.bkg == vet_pkg::RST_BKG) && setup_level_enable;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

endmodule : vet_timing_format

// *** vet_display_model.sv ***
// Purpose: display chain stand-in that counts active lines per field
// Assumes: field_start is a one-cycle pulse
// Notes: only rising edges of active video are counted, so line length is not checked here
`timescale 1ns/10ps
module vet_display_model (
    input wire logic clock,
    input wire logic active_video,
    input wire logic field_start,
    output logic [9:0] field_lines
);
    logic [9:0] count = 10'h000;
    logic was_active = 1'b0;
    initial field_lines = 10'h000;
    always @(posedge clock) begin
        was_active <= active_video;
        if (field_start) begin
            field_lines <= count;
            count <= 10'h000;
        end else if (active_video && !was_active) begin
            count <= count + 10'h001;
        end
    end
endmodule : vet_display_model

// *** video_encoder_timing_format_bench.sv ***
// Purpose: register and raster checks for the encoder timing block
// Assumes: short line lengths stand in for the real sample counts
// Notes: inputs move on the falling edge
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module video_encoder_timing_format_bench;
    logic clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, master_mode = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_rvalid, active_video, field_id, field_start, progressive, setup_level_enable;
    logic [9:0] line_number, field_lines;
    logic [2:0] field_sequence, analog_standard;
    logic [31:0] subcarrier_phase;
    vet_pkg::vet_pixel_t pix_in = '{8'h55, 8'h66, 8'h77}, pix_out;
    int errors = 0, compares = 0;
    logic [7:0] ra [8] = '{8'h00, 8'h01, 8'h08, 8'h11, 8'h12, 8'h13, 8'h14, 8'h02};
    logic [7:0] rv [8] = '{8'h01, 8'h12, 8'h03, 8'h3e, 8'hf8, 8'he0, 8'h43, 8'h00};
    vet_timing_format #(.LINE_SAMPLES_525(40), .LINE_SAMPLES_625(44), .ACTIVE_START(4), .ACTIVE_SAMPLES(16)) dut (
        .clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .master_mode(master_mode),
        .pix_in(pix_in), .pix_out(pix_out), .active_video(active_video), .line_number(line_number),
        .field_id(field_id), .field_sequence(field_sequence), .field_start(field_start),
        .analog_standard(analog_standard), .progressive(progressive),
        .setup_level_enable(setup_level_enable), .subcarrier_phase(subcarrier_phase));
    vet_display_model far_end (.clock(clock), .active_video(active_video), .field_start(field_start),
        .field_lines(field_lines));
    // ==========================================
    // bus and wait tasks
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, e)
        @(negedge clock);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        @(negedge clock);
    endtask : wr
    // bounded so a dead counter shows as a mismatch, not a hang
    // waits for a fresh rise, so a level still high from the last call is not taken again
    task automatic wait_on(input bit fs);
        int n;
        n = 0;
        while ((fs ? field_start : active_video) === 1'b1 && n < 30000) begin
            @(negedge clock);
            n++;
        end
        while ((fs ? field_start : active_video) !== 1'b1 && n < 30000) begin
            @(negedge clock);
            n++;
        end
        `CHK(n < 30000, 1'b1)
    endtask : wait_on
    task automatic tally_and_finish();
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    // ==========================================
    // sequence
    initial forever #12.5 clock = ~clock;
    initial begin
        repeat (3) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
        `CHK(setup_level_enable, 1'b1)
        wr(8'h02, 8'h5a);
        rd(8'h02, 8'h00);
        wait_on(1'b0);
        `CHK(pix_out, {8'h29, 8'hf0, 8'h6e})
        wait_on(1'b1);
        `CHK(line_number, 10'd264)
        `CHK(field_id, 1'b1)
        wait_on(1'b1);
        `CHK(field_id, 1'b0)
        // the display model latches its count one edge after the pulse
        @(negedge clock);
        `CHK(field_lines, 10'd240)
        wr(8'h00, 8'h05);
        wait_on(1'b0);
        `CHK(pix_out, pix_in)
        wr(8'h01, 8'h90);
        `CHK(setup_level_enable, 1'b0)
        wait_on(1'b0);
        `CHK(pix_out.y, 8'heb)
        master_mode = 1'b0;
        wait_on(1'b0);
        `CHK(pix_out, pix_in)
        master_mode = 1'b1;
        wr(8'h00, 8'h41);
        `CHK(analog_standard, 3'b010)
        wr(8'h11, 8'h96);
        wr(8'h12, 8'h15);
        wr(8'h13, 8'h13);
        wr(8'h14, 8'h54);
        wait_on(1'b1);
        wait_on(1'b1);
        @(negedge clock);
        `CHK(field_lines, 10'd288)
        wr(8'h00, 8'h09);
        `CHK(progressive, 1'b1)
        wait_on(1'b1);
        `CHK(field_sequence, 3'd0)
        @(negedge clock);
        `CHK(subcarrier_phase, 32'h00000000)
        @(negedge clock);
        `CHK(subcarrier_phase, 32'h54131596)
        rd(8'h0f, 8'h08);
        wait_on(1'b1);
        @(negedge clock);
        `CHK(field_lines, 10'd240)
        `CHK(field_id, 1'b0)
        rd(8'h0f, 8'h20);
        tally_and_finish();
    end
    initial begin
        repeat (95000) @(posedge clock);
        errors++;
        tally_and_finish();
    end
endmodule : video_encoder_timing_format_bench
